// >>> rtl/exec_core.sv
// Purpose: executes ALU, multiply, jump, skip and branch instructions
// Assumes: one instruction accepted when start is high and busy is low
// Notes: pc advance of an instruction is one word unless it jumps or skips
`include "exec_defs.svh"
module exec_core
   import exec_pkg::*;
#(
   parameter int PC_WIDTH = `PC_W
)
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic start,
   input exec_op_t op,
   input exec_operands_t opnd,
   input wire logic [21:0] pc_in,
   output logic busy,
   output logic done,
   output exec_write_t wr,
   output logic [21:0] pc_out,
   output logic [7:0] status_flags_reg,
   output logic [2:0] cycles_used
);
   initial
   begin
      if (PC_WIDTH < 16 || PC_WIDTH > 22)
         $error("PC_WIDTH out of range");
   end

   typedef enum {idle_st, wait_st} st_t;
   st_t st_q;
   logic [2:0] cnt_q;
   logic [2:0] len;
   logic [21:0] pc_new;
   logic [7:0] flags_new;
   exec_write_t wr_new;
   logic [7:0] res;
   logic [15:0] p;
   logic cond;
   logic skip;
   logic [7:0] f;

   ////////////////////////////////////////////////////////////////////
   function automatic logic [21:0] rel_target(input logic [21:0] pc,
                                              input logic [11:0] k);
      logic [21:0] ext;
      ext = {{10{k[11]}}, k};
      rel_target = pc + ext + 22'h000001;
   endfunction

   function automatic logic [7:0] logic_flags(input logic [7:0] fl,
                                              input logic [7:0] r);
      logic [7:0] o;
      o = fl;
      o[`FLAG_Z] = (r == 8'h00);
      o[`FLAG_N] = r[7];
      o[`FLAG_V] = 1'b0;
      o[`FLAG_S] = r[7];
      logic_flags = o;
   endfunction

   function automatic logic [7:0] sub_flags(input logic [7:0] fl,
                                            input logic [7:0] a,
                                            input logic [7:0] b,
                                            input logic ci,
                                            input logic keep_z);
      logic [7:0] o;
      logic [7:0] r;
      o = fl;
      r = a - b - {7'h00, ci};
      o[`FLAG_Z] = keep_z ? ((r == 8'h00) & fl[`FLAG_Z]) : (r == 8'h00);
      o[`FLAG_N] = r[7];
      o[`FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
      o[`FLAG_C] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
      o[`FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
      o[`FLAG_S] = o[`FLAG_N] ^ o[`FLAG_V];
      sub_flags = o;
   endfunction

   ////////////////////////////////////////////////////////////////////
   always_comb
   begin
      f = status_flags_reg;
      flags_new = f;
      wr_new = '0;
      pc_new = pc_in + 22'h000001;
      len = `CYC_ONE;
      res = 8'h00;
      p = 16'h0000;
      cond = 1'b0;
      skip = 1'b0;
      case (op)
         set_bits_op:
         begin
            res = opnd.rd | opnd.imm;
            wr_new.rd_we = 1'b1;
            wr_new.rd_val = res;
            flags_new = logic_flags(f, res);
         end
         clear_bits_op:
         begin
            res = opnd.rd & ~opnd.imm;
            wr_new.rd_we = 1'b1;
            wr_new.rd_val = res;
            flags_new = logic_flags(f, res);
         end
         test_op:
         begin
            res = opnd.rd & opnd.rd;
            flags_new = logic_flags(f, res);
         end
         clear_reg_op:
         begin
            res = opnd.rd ^ opnd.rd;
            wr_new.rd_we = 1'b1;
            wr_new.rd_val = res;
            flags_new = logic_flags(f, res);
         end
         set_all_ones_op:
         begin
            wr_new.rd_we = 1'b1;
            wr_new.rd_val = 8'hFF;
         end
         negate_op, inc_op, dec_op:
         begin
            if (op == negate_op)
               res = 8'h00 - opnd.rd;
            else if (op == inc_op)
               res = opnd.rd + 8'h01;
            else
               res = opnd.rd - 8'h01;
            wr_new.rd_we = 1'b1;
            wr_new.rd_val = res;
            flags_new = logic_flags(f, res);
            if (op == negate_op)
               flags_new = sub_flags(f, 8'h00, opnd.rd, 1'b0, 1'b0);
            else if (op == inc_op)
               flags_new[`FLAG_V] = (opnd.rd == 8'h7F);
            else
               flags_new[`FLAG_V] = (opnd.rd == 8'h80);
            flags_new[`FLAG_S] = flags_new[`FLAG_N] ^ flags_new[`FLAG_V];
         end
         mult_unsigned_op, frac_mult_unsigned_op:
            p = opnd.rd * opnd.rr;
         mult_signed_op, frac_mult_signed_op:
            p = 16'($signed(opnd.rd) * $signed(opnd.rr));
         mult_mixed_op, frac_mult_mixed_op:
            p = 16'($signed({{8{opnd.rd[7]}}, opnd.rd})
                    * $signed({8'h00, opnd.rr}));
         default:
            p = 16'h0000;
      endcase
      case (op)
         mult_unsigned_op, mult_signed_op, mult_mixed_op:
         begin
            wr_new.prod_we = 1'b1;
            wr_new.prod = p;
            flags_new[`FLAG_C] = p[15];
            flags_new[`FLAG_Z] = (p == 16'h0000);
            len = `CYC_MUL;
         end
         frac_mult_unsigned_op, frac_mult_signed_op, frac_mult_mixed_op:
         begin
            wr_new.prod_we = 1'b1;
            wr_new.prod = {p[14:0], 1'b0};
            flags_new[`FLAG_C] = p[15];
            flags_new[`FLAG_Z] = ({p[14:0], 1'b0} == 16'h0000);
            len = `CYC_MUL;
         end
         rel_jump_op:
         begin
            pc_new = rel_target(pc_in, opnd.offset);
            len = `CYC_JMP_PTR;
         end
         ptr_jump_op:
         begin
            pc_new = {6'h00, opnd.zptr};
            len = `CYC_JMP_PTR;
         end
         ext_ptr_jump_op:
         begin
            pc_new = {opnd.ext_ind[5:0], opnd.zptr};
            len = `CYC_JMP_PTR;
         end
         abs_jump_op:
         begin
            pc_new = opnd.target;
            len = 3'h3;
         end
         rel_call_op:
         begin
            pc_new = rel_target(pc_in, opnd.offset);
            len = `CYC_CALL_REL;
         end
         ptr_call_op:
         begin
            pc_new = {6'h00, opnd.zptr};
            len = `CYC_CALL_PTR;
         end
         abs_call_op:
         begin
            pc_new = opnd.target;
            len = `CYC_CALL_ABS;
         end
         sub_return_op, int_return_op:
         begin
            pc_new = opnd.stack_pc;
            len = `CYC_RET;
            if (op == int_return_op)
               flags_new[`FLAG_I] = 1'b1;
         end
         compare_op:
            flags_new = sub_flags(f, opnd.rd, opnd.rr, 1'b0, 1'b0);
         compare_carry_op:
            flags_new = sub_flags(f, opnd.rd, opnd.rr, f[`FLAG_C],
                                  1'b1);
         compare_imm_op:
            flags_new = sub_flags(f, opnd.rd, opnd.imm, 1'b0, 1'b0);
         cmp_skip_eq_op:
            skip = (opnd.rd == opnd.rr);
         skip_reg_bit_clr_op:
            skip = ~opnd.rr[opnd.bitsel];
         skip_reg_bit_set_op:
            skip = opnd.rr[opnd.bitsel];
         skip_io_bit_clr_op:
            skip = ~opnd.io_val[opnd.bitsel];
         skip_io_bit_set_op:
            skip = opnd.io_val[opnd.bitsel];
         default:
         begin
            case (op)
               branch_flag_set_op: cond = f[opnd.bitsel];
               branch_flag_clr_op: cond = ~f[opnd.bitsel];
               branch_equal_op: cond = f[`FLAG_Z];
               branch_not_equal_op: cond = ~f[`FLAG_Z];
               branch_carry_set_op: cond = f[`FLAG_C];
               branch_carry_clr_op: cond = ~f[`FLAG_C];
               branch_same_higher_op: cond = ~f[`FLAG_C];
               branch_ge_signed_op:
                  cond = ~(f[`FLAG_N] ^ f[`FLAG_V]);
               branch_lt_signed_op:
                  cond = f[`FLAG_N] ^ f[`FLAG_V];
               branch_halfcarry_set_op: cond = f[`FLAG_H];
               branch_halfcarry_clr_op: cond = ~f[`FLAG_H];
               branch_tbit_set_op: cond = f[`FLAG_T];
               branch_tbit_clr_op: cond = ~f[`FLAG_T];
               branch_overflow_set_op: cond = f[`FLAG_V];
               default: cond = 1'b0;
            endcase
            if (cond)
            begin
               pc_new = rel_target(pc_in, opnd.offset);
               len = `CYC_BR_TAKEN;
            end
         end
      endcase
      // skipping a two-word instruction costs one more cycle and word
      if (skip)
      begin
         pc_new = pc_in + (opnd.next_two_word ? 22'h000003 : 22'h000002);
         len = opnd.next_two_word ? 3'h3 : 3'h2;
      end
      if (PC_WIDTH < 22)
         pc_new = pc_new & ((22'h000001 << PC_WIDTH) - 22'h000001);
   end

   ////////////////////////////////////////////////////////////////////
   // results land on the first edge; done marks the last cycle
   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         st_q <= idle_st;
         cnt_q <= 3'h0;
         busy <= 1'b0;
         done <= 1'b0;
      end
      else
      begin
         case (st_q)
            idle_st:
            begin
               done <= 1'b0;
               if (start)
               begin
                  if (len == `CYC_ONE)
                     done <= 1'b1;
                  else
                  begin
                     busy <= 1'b1;
                     cnt_q <= len - 3'h1;
                     st_q <= wait_st;
                  end
               end
            end
            wait_st:
            begin
               cnt_q <= cnt_q - 3'h1;
               if (cnt_q == 3'h1)
               begin
                  busy <= 1'b0;
                  done <= 1'b1;
                  st_q <= idle_st;
               end
            end
            default:
               st_q <= idle_st;
         endcase
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         wr <= '0;
         pc_out <= 22'h000000;
         status_flags_reg <= 8'h00;
         cycles_used <= 3'h0;
      end
      else
      begin
         wr <= '0;
         if (st_q == idle_st && start)
         begin
            wr <= wr_new;
            pc_out <= pc_new;
            status_flags_reg <= flags_new;
            cycles_used <= len;
         end
      end
   end
endmodule

// >>> rtl/exec_defs.svh
// Operation
// - set-bits ORs mask, one cycle, flags
// - clear-bits ANDs complement mask, one cycle
// - test ANDs register with itself, flags only
// - multiplies write R1:R0, two cycles, Z C
// - fractional multiplies shift product left once
// - pointer jump loads PC from Z, two cycles
// - extended jump loads PC from ext:Z
// - relative call PC+k+1, four cycles
// - pointer call loads PC from Z, four cycles
// - direct call absolute, five cycles, no flags
// - compare-skip on equal, PC+2 or 3
// - compares subtract without storing, set flags
// - register bit skips on clear or set
// - io bit skips on clear or set
// - generic flag branches, one or two cycles
// - equal tests Z, carry branches test C
// - same-or-higher taken when C clear
// - signed ge when N^V zero, lt one
// - half-carry branches test H
// - T branches test transfer bit
// - overflow-set branch tests V
//
// Purpose: constants for the execute block
// Assumes: included by the core, the checker and the bench
// Notes: status bit positions follow the usual I T H S V N Z C order
`ifndef EXEC_DEFS_SVH
`define EXEC_DEFS_SVH
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAG_T 6
`define FLAG_I 7
`define PC_W 22
`define CYC_MUL 3'h2
`define CYC_JMP_PTR 3'h2
`define CYC_CALL_REL 3'h4
`define CYC_CALL_PTR 3'h4
`define CYC_CALL_ABS 3'h5
`define CYC_RET 3'h5
`define CYC_BR_TAKEN 3'h2
`define CYC_ONE 3'h1
`endif

// >>> rtl/exec_pkg.sv
// Purpose: types for the execute block
// Assumes: exec_defs.svh present
// Notes: opcode set limited to this block
package exec_pkg;
   typedef enum {
      nop_op, negate_op, set_bits_op, clear_bits_op, inc_op, dec_op,
      test_op, clear_reg_op, set_all_ones_op, mult_unsigned_op,
      mult_signed_op, mult_mixed_op, frac_mult_unsigned_op,
      frac_mult_signed_op, frac_mult_mixed_op, rel_jump_op, ptr_jump_op,
      ext_ptr_jump_op, abs_jump_op, rel_call_op, ptr_call_op,
      abs_call_op, sub_return_op, int_return_op, cmp_skip_eq_op,
      compare_op, compare_carry_op, compare_imm_op, skip_reg_bit_clr_op,
      skip_reg_bit_set_op, skip_io_bit_clr_op, skip_io_bit_set_op,
      branch_flag_set_op, branch_flag_clr_op, branch_equal_op,
      branch_not_equal_op, branch_carry_set_op, branch_carry_clr_op,
      branch_same_higher_op, branch_ge_signed_op, branch_lt_signed_op,
      branch_halfcarry_set_op, branch_halfcarry_clr_op,
      branch_tbit_set_op, branch_tbit_clr_op, branch_overflow_set_op
   } exec_op_t;
   typedef struct packed {
      logic [7:0] rd;
      logic [7:0] rr;
      logic [7:0] imm;
      logic [2:0] bitsel;
      logic [11:0] offset;
      logic [21:0] target;
      logic [15:0] zptr;
      logic [7:0] ext_ind;
      logic [21:0] stack_pc;
      logic [7:0] io_val;
      logic next_two_word;
   } exec_operands_t;
   typedef struct packed {
      logic rd_we;
      logic [7:0] rd_val;
      logic prod_we;
      logic [15:0] prod;
   } exec_write_t;
endpackage

// >>> tb/exec_core_checker.sv
// Purpose: port-level checks on the execute block
// Assumes: a request is taken at an edge with start high and busy low
// Notes: results are judged from the edge after the request
`include "exec_defs.svh"
module exec_core_checker
   import exec_pkg::*;
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic start,
   input exec_op_t op,
   input exec_operands_t opnd,
   input wire logic [21:0] pc_in,
   input wire logic busy,
   input wire logic done,
   input exec_write_t wr,
   input wire logic [21:0] pc_out,
   input wire logic [7:0] status_flags_reg,
   input wire logic [2:0] cycles_used
);
   ///////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);
   logic go;
   logic [15:0] mul_exp;
   logic [21:0] rel_tgt;
   assign go = start && !busy;
   assign mul_exp = {8'h00, opnd.rd} * {8'h00, opnd.rr};
   // offset is signed, so it is extended before the add
   assign rel_tgt = pc_in + {{10{opnd.offset[11]}}, opnd.offset} + 22'h1;
   sequence fin_s;
      done && !busy;
   endsequence
   sequence call_s;
      busy [*3] ##1 fin_s;
   endsequence
   chk_set_bits_or:
   assert property (go && op == set_bits_op |=> wr.rd_we && wr.rd_val ==
      ($past(opnd.rd) | $past(opnd.imm)) ##0 fin_s) else $error("set bits");
   chk_clear_bits_and:
   assert property (go && op == clear_bits_op |=> wr.rd_we && wr.rd_val ==
      ($past(opnd.rd) & ~$past(opnd.imm)) ##0 fin_s) else $error("clr bits");
   chk_mul_product:
   assert property (go && op == mult_unsigned_op |=> wr.prod_we &&
      wr.prod == $past(mul_exp) ##1 fin_s) else $error("multiply");
   chk_frac_shift:
   assert property (go && op == frac_mult_unsigned_op |=> wr.prod_we &&
      wr.prod == ($past(mul_exp) << 1) ##1 fin_s) else $error("frac mul");
   chk_ptr_jump_z:
   assert property (go && op == ptr_jump_op |=> pc_out == {6'h00,
      $past(opnd.zptr)} && $stable(status_flags_reg) ##1 fin_s)
      else $error("pointer jump");
   chk_rel_call_len:
   assert property (go && op == rel_call_op |=> pc_out == $past(rel_tgt)
      ##0 call_s) else $error("relative call");
   chk_abs_call_flags:
   assert property (go && op == abs_call_op |=> $stable(status_flags_reg)
      throughout (busy [*4] ##1 fin_s)) else $error("direct call");
   chk_branch_eq_taken:
   assert property (go && op == branch_equal_op && status_flags_reg[1]
      |=> pc_out == $past(rel_tgt) ##1 fin_s) else $error("branch equal");
   chk_cmp_zero_flag:
   assert property (go && op == compare_op |=> status_flags_reg[`FLAG_Z] ==
      ($past(opnd.rd) == $past(opnd.rr))) else $error("compare zero");
endmodule
bind exec_core exec_core_checker chk (.core_clk(core_clk),
   .resetn(resetn), .start(start), .op(op), .opnd(opnd), .pc_in(pc_in),
   .busy(busy), .done(done), .wr(wr), .pc_out(pc_out),
   .status_flags_reg(status_flags_reg), .cycles_used(cycles_used));

// >>> tb/exec_core_tb_top.sv
// Purpose: self-checking bench for the execute block
// Assumes: inputs change 2 ns after the rising edge
// Notes: flags carry from row to row, so row order matters
`include "exec_defs.svh"
module exec_core_tb_top
   import exec_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {
      exec_op_t op;
      logic [7:0] rd, rr, imm;
      logic [21:0] pc;
      logic [1:0] we;
      logic [15:0] val;
      logic [2:0] cyc;
   } row_t;
   logic core_clk, resetn, start, busy, done;
   exec_op_t op;
   exec_operands_t opnd;
   logic [21:0] pc_in, pc_out;
   exec_write_t wr;
   logic [7:0] status_flags_reg;
   logic [2:0] cycles_used;
   int n_errors = 0;
   int checks_done = 0;
   // we = 3 means the write port is not judged
   row_t rows [28] = '{
      '{set_bits_op,8'h50,8'h0,8'h0A,22'h21,2'h1,16'h5A,3'h1},
      '{clear_bits_op,8'h5A,8'h0,8'h0F,22'h21,2'h1,16'h50,3'h1},
      '{test_op,8'h80,8'h0,8'h0,22'h21,2'h3,16'h0,3'h1},
      '{branch_flag_set_op,8'h0,8'h0,8'h2,22'h23,2'h0,16'h0,3'h2},
      '{branch_lt_signed_op,8'h0,8'h0,8'hFE,22'h1F,2'h0,16'h0,3'h2},
      '{negate_op,8'h1,8'h0,8'h0,22'h21,2'h1,16'hFF,3'h1},
      '{clear_reg_op,8'h33,8'h0,8'h0,22'h21,2'h1,16'h0,3'h1},
      '{set_all_ones_op,8'h0,8'h0,8'h0,22'h21,2'h1,16'hFF,3'h1},
      '{branch_equal_op,8'h0,8'h0,8'h5,22'h26,2'h0,16'h0,3'h2},
      '{branch_not_equal_op,8'h0,8'h0,8'h5,22'h21,2'h0,16'h0,3'h1},
      '{mult_unsigned_op,8'h3,8'h4,8'h0,22'h21,2'h2,16'hC,3'h2},
      '{mult_mixed_op,8'hFF,8'h2,8'h0,22'h21,2'h2,16'hFFFE,3'h2},
      '{branch_same_higher_op,8'h0,8'h0,8'h5,22'h21,2'h0,16'h0,3'h1},
      '{frac_mult_unsigned_op,8'h80,8'h80,8'h0,22'h21,2'h2,16'h8000,3'h2},
      '{branch_carry_clr_op,8'h0,8'h0,8'h5,22'h26,2'h0,16'h0,3'h2},
      '{compare_op,8'h5,8'h5,8'h0,22'h21,2'h0,16'h0,3'h1},
      '{compare_carry_op,8'h7,8'h7,8'h0,22'h21,2'h0,16'h0,3'h1},
      '{branch_equal_op,8'h0,8'h0,8'h5,22'h26,2'h0,16'h0,3'h2},
      '{compare_op,8'h3,8'h5,8'h0,22'h21,2'h0,16'h0,3'h1},
      '{branch_halfcarry_set_op,8'h0,8'h0,8'h5,22'h26,2'h0,16'h0,3'h2},
      '{branch_tbit_clr_op,8'h0,8'h0,8'h5,22'h26,2'h0,16'h0,3'h2},
      '{ptr_jump_op,8'h0,8'h0,8'h0,22'h40,2'h0,16'h0,3'h2},
      '{ext_ptr_jump_op,8'h0,8'h0,8'h0,22'h10040,2'h0,16'h0,3'h2},
      '{rel_call_op,8'h0,8'h0,8'h5,22'h26,2'h0,16'h0,3'h4},
      '{abs_call_op,8'h0,8'h0,8'h0,22'h50,2'h0,16'h0,3'h5},
      '{cmp_skip_eq_op,8'h11,8'h11,8'h80,22'h23,2'h0,16'h0,3'h3},
      '{skip_io_bit_set_op,8'h0,8'h0,8'h3,22'h22,2'h0,16'h0,3'h2},
      '{int_return_op,8'h0,8'h0,8'h0,22'h60,2'h0,16'h0,3'h5}};
   exec_core DUT (.core_clk(core_clk), .resetn(resetn), .start(start),
      .op(op), .opnd(opnd), .pc_in(pc_in), .busy(busy), .done(done),
      .wr(wr), .pc_out(pc_out), .status_flags_reg(status_flags_reg),
      .cycles_used(cycles_used));
   ///////////////////////////////////////////////////////////////////////
   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   task automatic check(input string what, input logic [21:0] seen,
      input logic [21:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic rst;
      resetn = 1'b0;
      start = 1'b0;
      repeat (5) @(posedge core_clk);
      #2 check("reset", {9'h0, busy, done, status_flags_reg, cycles_used},
         22'h0);
      check("reset_pc", pc_out, 22'h0);
      resetn = 1'b1;
   endtask
   task automatic run(input row_t r);
      logic [21:0] n;
      logic [21:0] pc_s;
      logic [17:0] w_s;
      start = 1'b1;
      op = r.op;
      opnd = '{r.rd, r.rr, r.imm, r.imm[2:0], {{4{r.imm[7]}}, r.imm},
         22'h50, 16'h40, 8'h1, 22'h60, 8'h5A, r.imm[7]};
      pc_in = 22'h20;
      @(posedge core_clk);
      // results and a one-cycle done already stand after the taking edge
      #2 start = 1'b0;
      n = 22'h1;
      pc_s = pc_out;
      w_s = {wr.prod_we, wr.rd_we, wr.prod_we ? wr.prod
         : (wr.rd_we ? {8'h00, wr.rd_val} : 16'h0)};
      while (n < 22'h8 && done !== 1'b1)
      begin
         @(posedge core_clk);
         #2 n = n + 22'h1;
      end
      if (done !== 1'b1)
      begin
         n_errors++;
         $display("ERROR done expected 1 seen %b", done);
         end_sim();
      end
      check("cycles", n, 22'(r.cyc));
      check("cycles_used", 22'(cycles_used), 22'(r.cyc));
      check("pc_out", pc_s, r.pc);
      if (r.we != 2'h3)
         check("write", 22'(w_s), 22'({r.we, r.val}));
   endtask
   initial
   begin
      resetn = 1'b0;
      start = 1'b0;
      op = nop_op;
      opnd = '0;
      pc_in = 22'h0;
      #2;
      rst();
      foreach (rows[i])
         run(rows[i]);
      check("flag_i", 22'(status_flags_reg[`FLAG_I]), 22'h1);
      // a second request while busy must leave the call untouched
      op = abs_call_op;
      start = 1'b1;
      @(posedge core_clk);
      #2 start = 1'b0;
      @(posedge core_clk);
      #2 op = ptr_jump_op;
      start = 1'b1;
      @(posedge core_clk);
      #2 start = 1'b0;
      repeat (2) @(posedge core_clk);
      #2 check("refused_pc", pc_out, 22'h50);
      check("refused_done", 22'(done), 22'h1);
      op = abs_call_op;
      start = 1'b1;
      @(posedge core_clk);
      #2 rst();
      run(rows[0]);
      end_sim();
   end
endmodule
